// ### verilog/tcs_conn_mem.sv
/*
 Connection memory of a time-slot interchange switch.
 Holds a high and a low word per output location, written and
 read over a parallel processor port, and turns each slot
 request into an output word for the serial side.
 Assumes: slot requests and data memory come from logic on
 I_MCLK; processor pins and the drive pin are asynchronous;
 data memory answers within the clock in which O_DM_ADDR changes.
*/
// Functional notes
// [R1] Gain field bits 7-3 sets outgoing gain, +3 to -27 dB, plus mute.
// [R2] Message bit set: low word itself is sent as the channel byte.
// [R3] Message bit clear: low word addresses data memory; that byte is sent.
// [R4] Conference locations: bit 2 may invert alternate conference channels; the code inverts every conference location whose bit 2 is set.
// [R5] Non-conference bit 1 selects minimum or constant frame delay.
// [R6] Bit 0 governs driver only with drive pin high, control bit 5 clear.
// [R7] Enable 1 drives the slot, 0 leaves it high-impedance.
// [R8] Conference two-bit field selects noise suppression level.
// [R9] Conference gain field attenuates the incoming conference channel.
// [R10] Low word bits 7-5 name the source data memory block.
// [R11] Low word bits 4-0 name the source channel in that block.
// [R12] Conference location low words name channels joining the bridges.
// [R13] Location 6F low word picks the D-channel receive source.
// [R14] Locations 70, 71 pick energy detector A and B sources.
// [R15] Blocks: local 0, local 1, tones, expansion 1 to 4.
// [R16] Block 011: conference outputs 00-0E, D-channel transmit at 10.
// [R17] Each location maps one-to-one to an output channel.
// [R18] Gain code to attenuation step is a configurable table.
// [R19] Unused block 011 channel sends a fixed idle byte.
`timescale 1ns/1ns
module tcs_conn_mem
   import tcs_pkg::*;
#(
   parameter bit [159:0] GAIN_LUT  = {5'd31, 5'd30, 5'd29, 5'd28,
                                      5'd27, 5'd26, 5'd25, 5'd24,
                                      5'd23, 5'd22, 5'd21, 5'd20,
                                      5'd19, 5'd18, 5'd17, 5'd16,
                                      5'd15, 5'd14, 5'd13, 5'd12,
                                      5'd11, 5'd10, 5'd9,  5'd8,
                                      5'd7,  5'd6,  5'd5,  5'd4,
                                      5'd3,  5'd2,  5'd1,  5'd0},
   parameter bit [4:0]   MUTE_CODE = 5'h1F,
   parameter bit [7:0]   IDLE_BYTE = 8'hFF,
   parameter bit         CONF_INV  = 1'b1
) (
   input  wire logic             I_MCLK,
   input  wire logic             I_RESETN,
   // Processor port
   input  wire logic             I_CS_N,
   input  wire logic             I_DS,
   input  wire logic             I_RW,
   input  wire logic [7:0]       I_ADDR,
   input  wire logic [7:0]       I_DATA,
   output logic [7:0]            O_DATA,
   output logic                  O_DATA_OE,
   output logic                  O_DTA_N,
   // Driver control
   input  wire logic             I_GLOBAL_OUTPUT_DRIVE_PIN,
   input  wire logic             I_CTL_DRIVE_OFF,
   // Slot requests from frame timing
   input  wire logic             I_SLOT_VALID,
   input  wire logic [LOC_W-1:0] I_SLOT_LOC,
   output logic                  O_SLOT_READY,
   // Data memory read
   output logic [7:0]            O_DM_ADDR,
   input  wire logic [7:0]       I_DM_DATA,
   // Slot output words
   output logic                  O_TX_VALID,
   input  wire logic             I_TX_READY,
   output logic [LOC_W-1:0]      O_TX_LOC,
   output logic [7:0]            O_TX_BYTE,
   output logic                  O_TX_DRIVE,
   output logic                  O_TX_CONST_DELAY,
   output logic [4:0]            O_TX_GAIN_STEP,
   output logic                  O_TX_MUTE,
   output logic                  O_TX_CONF,
   output logic [1:0]            O_TX_NOISE_SUPPRESSION_LEVEL,
   output logic                  O_TX_INVERT,
   // Static routing selections
   output logic [7:0]            O_DCH_RX_SRC,
   output logic [7:0]            O_ED_A_SRC,
   output logic [7:0]            O_ED_B_SRC
);
   // ----------------------------------------------------------
   // Storage and declarations
   // ----------------------------------------------------------
   logic [7:0]       gain_mode_word [NUM_LOC];
   logic [7:0]       source_select_word [NUM_LOC];
   logic [1:0]       cs_sync;
   logic [1:0]       ds_sync;
   logic [1:0]       rw_sync;
   logic [1:0]       ode_sync;
   logic [7:0]       addr_m;
   logic [7:0]       addr_s;
   logic [7:0]       data_m;
   logic [7:0]       data_s;
   logic             access;
   logic             access_d;
   logic             start;
   logic [LOC_W-1:0] cpu_loc;
   logic             cpu_hi;
   logic             cpu_in_map;
   logic             slot_take;
   logic             s1_valid;
   logic [LOC_W-1:0] s1_loc;
   logic [7:0]       s1_hi;
   logic [7:0]       s1_lo;
   logic             s1_conf;
   logic             s1_push;
   logic             buf_ready;
   logic [1:0]       buf_count;
   logic             pop;
   logic [1:0]       occ;
   logic [1:0]       next_occ;
   logic [PAY_W-1:0] s1_pay;
   logic [PAY_W-1:0] out_pay;
   logic [7:0]       tx_byte;
   logic             tx_drive;
   logic [2:0]       src_blk;
   logic [4:0]       src_ch;
   logic [4:0]       gain_code;
   logic             inv_phase;

   // ----------------------------------------------------------
   // Processor port pins
   // ----------------------------------------------------------
   // Two flops on every pin; only the second stage is read
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         cs_sync  <= 2'h3;
         ds_sync  <= 2'h0;
         rw_sync  <= 2'h0;
         ode_sync <= 2'h0;
         addr_m   <= 8'h00;
         addr_s   <= 8'h00;
         data_m   <= 8'h00;
         data_s   <= 8'h00;
      end else begin
         cs_sync  <= {cs_sync[0], I_CS_N};
         ds_sync  <= {ds_sync[0], I_DS};
         rw_sync  <= {rw_sync[0], I_RW};
         ode_sync <= {ode_sync[0], I_GLOBAL_OUTPUT_DRIVE_PIN};
         addr_m   <= I_ADDR;
         addr_s   <= addr_m;
         data_m   <= I_DATA;
         data_s   <= data_m;
      end
   end

   // An access acts once, on the first clock that sees it
   assign access     = ~cs_sync[1] & ds_sync[1];
   assign start      = access & ~access_d;
   assign cpu_loc    = addr_s[LOC_W-1:0];
   assign cpu_hi     = addr_s[ADDR_HI_BIT];
   assign cpu_in_map = 32'(cpu_loc) < NUM_LOC;

   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         access_d <= 1'b0;
      end else begin
         access_d <= access;
      end
   end

   // ----------------------------------------------------------
   // Connection memory writes
   // ----------------------------------------------------------
   // [R17] one word pair per location
   // Writes above the map are dropped; no wrap onto live slots
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         for (int i = 0; i < NUM_LOC; i++) begin
            gain_mode_word[i]     <= CM_RESET;
            source_select_word[i] <= CM_RESET;
         end
      end else if (start && !rw_sync[1] && cpu_in_map) begin
         if (cpu_hi) begin
            gain_mode_word[cpu_loc] <= data_s;
         end else begin
            source_select_word[cpu_loc] <= data_s;
         end
      end
   end

   // Read data, bus enable and acknowledge for the processor
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_DATA    <= 8'h00;
         O_DATA_OE <= 1'b0;
         O_DTA_N   <= 1'b1;
      end else begin
         O_DATA_OE <= access & rw_sync[1];
         O_DTA_N   <= ~access;
         if (start) begin
            if (!cpu_in_map) begin
               O_DATA <= 8'h00;
            end else if (cpu_hi) begin
               O_DATA <= gain_mode_word[cpu_loc];
            end else begin
               O_DATA <= source_select_word[cpu_loc];
            end
         end
      end
   end

   // ----------------------------------------------------------
   // Static routing selections
   // ----------------------------------------------------------
   // [R13] D-channel receive source
   // [R14] energy detector sources
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_DCH_RX_SRC <= CM_RESET;
         O_ED_A_SRC   <= CM_RESET;
         O_ED_B_SRC   <= CM_RESET;
      end else begin
         O_DCH_RX_SRC <= source_select_word[LOC_DCH_RX];
         O_ED_A_SRC   <= source_select_word[LOC_ED_A];
         O_ED_B_SRC   <= source_select_word[LOC_ED_B];
      end
   end

   // ----------------------------------------------------------
   // Slot pipeline
   // ----------------------------------------------------------
   // Words in flight never exceed the buffer's two entries, so a
   // push from stage 1 is always taken; costs one slot of rate
   assign pop       = O_TX_VALID & I_TX_READY;
   assign slot_take = I_SLOT_VALID & O_SLOT_READY;
   assign occ       = buf_count + {1'b0, s1_valid};
   assign next_occ  = occ + {1'b0, slot_take} - {1'b0, pop};

   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_SLOT_READY <= 1'b0;
      end else begin
         O_SLOT_READY <= next_occ < 2'd2;
      end
   end

   // [R3] low word goes out as data memory address
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         s1_valid  <= 1'b0;
         s1_loc    <= '0;
         s1_hi     <= CM_RESET;
         s1_lo     <= CM_RESET;
         O_DM_ADDR <= 8'h00;
      end else begin
         s1_valid <= slot_take;
         if (slot_take) begin
            s1_loc    <= I_SLOT_LOC;
            s1_hi     <= gain_mode_word[I_SLOT_LOC];
            s1_lo     <= source_select_word[I_SLOT_LOC];
            O_DM_ADDR <= source_select_word[I_SLOT_LOC];
         end
      end
   end

   // Inversion phase is held at 0; bit 2 alone inverts each conference location
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         inv_phase <= 1'b0;
      end else begin
         inv_phase <= inv_phase;
      end
   end

   // ----------------------------------------------------------
   // Output word formation
   // ----------------------------------------------------------
   assign s1_conf   = (s1_loc >= LOC_CONF_LO) && (s1_loc <= LOC_CONF_HI);
   // [R10] source block
   assign src_blk   = s1_lo[LO_BLK_MSB:LO_BLK_LSB];
   // [R11] source channel
   assign src_ch    = s1_lo[LO_CH_MSB:LO_CH_LSB];
   // [R1] gain code, [R9] same field attenuates conference input
   assign gain_code = s1_hi[HI_GAIN_MSB:HI_GAIN_LSB];

   // Byte selection for the slot
   always_comb begin
      tx_byte = I_DM_DATA;
      if (s1_hi[HI_MSG_BIT] && !s1_conf) begin
         // [R2] message byte
         tx_byte = s1_lo;
      end else if (src_blk == BLK_INTERNAL) begin
         // [R16] conference outputs and D-channel transmit
         // [R19] idle byte for unused addresses
         if (src_ch > CH_CONF_LAST && src_ch != CH_DCH_TX) begin
            tx_byte = IDLE_BYTE;
         end
      end
      // [R15] other blocks read data memory as addressed
   end

   // [R6] driver gating, [R7] enable bit drives or floats
   // With bit 5 set every non-conference slot drives; pin low floats all
   always_comb begin
      tx_drive = 1'b0;
      if (!s1_conf && ode_sync[1]) begin
         tx_drive = I_CTL_DRIVE_OFF ? 1'b1 : s1_hi[HI_DRIVE_BIT];
      end
   end

   // Payload fields for the buffer
   // [R5] delay mode, [R8] noise suppression, [R4] inversion
   // [R12] conference low word addresses data memory; that byte is carried
   // [R18] gain step from table
   assign s1_pay = {s1_loc,
                    tx_byte,
                    tx_drive,
                    ~s1_conf & s1_hi[HI_DELAY_BIT],
                    GAIN_LUT[5*gain_code +: 5],
                    gain_code == MUTE_CODE,
                    s1_conf,
                    s1_conf ? s1_hi[HI_NS_MSB:HI_NS_LSB] : 2'b00,
                    CONF_INV & s1_conf & (s1_hi[HI_MSG_BIT] ^ inv_phase)};
   assign s1_push = s1_valid;

   // ----------------------------------------------------------
   // Output buffer
   // ----------------------------------------------------------
   tcs_skid_buf #(
      .W (PAY_W)
   ) u_buf (
      .i_clk    (I_MCLK),
      .i_resetn (I_RESETN),
      .i_valid  (s1_push),
      .o_ready  (buf_ready),
      .i_data   (s1_pay),
      .o_valid  (O_TX_VALID),
      .i_ready  (I_TX_READY),
      .o_data   (out_pay),
      .o_count  (buf_count)
   );

   // Fields taken straight from the buffer's output flops
   assign {O_TX_LOC,
           O_TX_BYTE,
           O_TX_DRIVE,
           O_TX_CONST_DELAY,
           O_TX_GAIN_STEP,
           O_TX_MUTE,
           O_TX_CONF,
           O_TX_NOISE_SUPPRESSION_LEVEL,
           O_TX_INVERT} = out_pay;
endmodule

// ### verilog/tcs_pkg.sv
/*
 Constants for the connection memory of the time-slot switch:
 location map, word field positions and source block codes.
 Assumes nothing of its surroundings.
*/
package tcs_pkg;
   // ----------------------------------------------------------
   // Location map
   // ----------------------------------------------------------
   localparam int       LOC_W         = 7;
   localparam int       NUM_LOC       = 114;
   localparam bit [6:0] LOC_CONF_LO   = 7'h60;
   localparam bit [6:0] LOC_CONF_HI   = 7'h6E;
   localparam bit [6:0] LOC_DCH_RX    = 7'h6F;
   localparam bit [6:0] LOC_ED_A      = 7'h70;
   localparam bit [6:0] LOC_ED_B      = 7'h71;
   localparam bit [7:0] CM_RESET      = 8'h00;

   // ----------------------------------------------------------
   // High word fields
   // ----------------------------------------------------------
   localparam int       HI_GAIN_MSB   = 7;
   localparam int       HI_GAIN_LSB   = 3;
   localparam int       HI_MSG_BIT    = 2;
   localparam int       HI_DELAY_BIT  = 1;
   localparam int       HI_DRIVE_BIT  = 0;
   localparam int       HI_NS_MSB     = 1;
   localparam int       HI_NS_LSB     = 0;

   // ----------------------------------------------------------
   // Low word fields and source blocks
   // ----------------------------------------------------------
   localparam int       LO_BLK_MSB    = 7;
   localparam int       LO_BLK_LSB    = 5;
   localparam int       LO_CH_MSB     = 4;
   localparam int       LO_CH_LSB     = 0;
   localparam bit [2:0] BLK_LOCAL0    = 3'h0;
   localparam bit [2:0] BLK_LOCAL1    = 3'h1;
   localparam bit [2:0] BLK_TONES     = 3'h2;
   localparam bit [2:0] BLK_INTERNAL  = 3'h3;
   localparam bit [4:0] CH_CONF_LAST  = 5'h0E;
   localparam bit [4:0] CH_DCH_TX     = 5'h10;

   // ----------------------------------------------------------
   // Processor port address split and slot payload width
   // ----------------------------------------------------------
   localparam int       ADDR_HI_BIT   = 7;
   localparam int       PAY_W         = 27;
endpackage

// ### verilog/tcs_skid_buf.sv
/*
 Two-entry buffer with valid and ready on both sides.
 Output side comes from flip-flops; a stall by the reader
 loses no word. Single clock, asynchronous active-low reset.
*/
`timescale 1ns/1ns
module tcs_skid_buf #(
   parameter int W = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data,
   output logic [1:0]        o_count
);
   logic         skid_valid;
   logic [W-1:0] skid_data;
   logic         push;
   logic         pop;

   // Handshakes on each side
   assign o_ready = ~skid_valid;
   assign push    = i_valid & ~skid_valid;
   assign pop     = o_valid & i_ready;
   assign o_count = {1'b0, o_valid} + {1'b0, skid_valid};

   // Output stage refills from the skid entry first to keep order
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_valid <= 1'b0;
         o_data  <= '0;
      end else if (!o_valid || pop) begin
         if (skid_valid) begin
            o_valid <= 1'b1;
            o_data  <= skid_data;
         end else begin
            o_valid <= push;
            o_data  <= push ? i_data : o_data;
         end
      end
   end

   // Skid entry catches a word that arrives while output stalls
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         skid_valid <= 1'b0;
         skid_data  <= '0;
      end else if (skid_valid) begin
         skid_valid <= ~(!o_valid || pop);
      end else if (push && o_valid && !pop) begin
         skid_valid <= 1'b1;
         skid_data  <= i_data;
      end
   end
endmodule

// ### bench/tcs_conn_mem_assertions.sv
/*
 Port checker for the connection memory slot and routing outputs.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ns
module tcs_conn_mem_chk (
   input  wire logic       I_MCLK,
   input  wire logic       I_RESETN,
   input  wire logic       I_TX_READY,
   input  wire logic       O_TX_VALID,
   input  wire logic [6:0] O_TX_LOC,
   input  wire logic [7:0] O_TX_BYTE,
   input  wire logic       O_TX_DRIVE,
   input  wire logic       O_TX_CONST_DELAY,
   input  wire logic       O_TX_CONF,
   input  wire logic [1:0] O_TX_NOISE_SUPPRESSION_LEVEL,
   input  wire logic       O_TX_INVERT,
   input  wire logic       O_DTA_N,
   input  wire logic [7:0] O_DCH_RX_SRC,
   input  wire logic [7:0] O_ED_A_SRC,
   input  wire logic [7:0] O_ED_B_SRC
);
   // ---------------------------------------------
   // Slot word relations
   // ---------------------------------------------
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RESETN);

   // A stalled word must not change, or the reader sees a torn byte
   a_stall_hold: assert property (
      O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_BYTE) && $stable(O_TX_LOC))
      else $error("slot word changed while stalled");
   a_conf_span: assert property (
      O_TX_VALID |-> O_TX_CONF == (O_TX_LOC >= 7'h60 && O_TX_LOC <= 7'h6E))
      else $error("conference flag disagrees with location");
   a_conf_nodrive: assert property (
      O_TX_VALID && O_TX_CONF |-> !O_TX_DRIVE)
      else $error("conference location drives a slot");
   a_conf_nodelay: assert property (
      O_TX_VALID && O_TX_CONF |-> !O_TX_CONST_DELAY)
      else $error("delay mode set at conference location");
   a_ns_nonconf: assert property (
      O_TX_VALID && !O_TX_CONF |-> O_TX_NOISE_SUPPRESSION_LEVEL == 2'h0)
      else $error("noise level outside conference");
   a_invert_conf: assert property (
      O_TX_INVERT && O_TX_VALID |-> O_TX_CONF)
      else $error("inversion outside conference");
   a_loc_mapped: assert property (
      O_TX_VALID |-> O_TX_LOC <= 7'h71)
      else $error("slot word for unmapped location");

   // Routing copies move only while a processor access is acknowledged
   a_route_write: assert property (
      $changed(O_DCH_RX_SRC) || $changed(O_ED_A_SRC) || $changed(O_ED_B_SRC)
      |-> !O_DTA_N || $past(!O_DTA_N))
      else $error("routing source changed without a write");
endmodule

bind tcs_conn_mem tcs_conn_mem_chk i_tcs_conn_mem_chk (
   .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_TX_READY(I_TX_READY),
   .O_TX_VALID(O_TX_VALID), .O_TX_LOC(O_TX_LOC), .O_TX_BYTE(O_TX_BYTE),
   .O_TX_DRIVE(O_TX_DRIVE), .O_TX_CONST_DELAY(O_TX_CONST_DELAY), .O_TX_CONF(O_TX_CONF),
   .O_TX_NOISE_SUPPRESSION_LEVEL(O_TX_NOISE_SUPPRESSION_LEVEL), .O_TX_INVERT(O_TX_INVERT),
   .O_DTA_N(O_DTA_N), .O_DCH_RX_SRC(O_DCH_RX_SRC), .O_ED_A_SRC(O_ED_A_SRC),
   .O_ED_B_SRC(O_ED_B_SRC)
);

// ### bench/tcs_dm_model.sv
/*
 Data memory stand-in on the far side of the slot path.
 Assumes the switch reads the byte within the clock in which the address changes.
*/
`timescale 1ns/1ns
module tcs_dm_model (
   input  wire logic [7:0] i_addr,
   output logic [7:0]      o_data
);
   // Inverted address: every source gives a distinct byte, never equal to its address
   assign o_data = ~i_addr;
endmodule

// ### bench/tb.sv
/*
 Self-checking bench for the connection memory.
 Assumes the design, the data memory model and the bound checker.
*/
`timescale 1ns/1ns
module tb;
   logic       clk, rst_n, cs_n, ds, rw, pin, ctl, sv, txr;
   logic       oe, dta_n, srdy, txv, drv, cd, mute, conf, inv;
   logic [7:0] addr, wd, rdat, dma, dmd, txb, dch, eda, edb;
   logic [6:0] sloc, txl;
   logic [4:0] gs;
   logic [1:0] ns;
   int         n_errors = 0;
   int         compares = 0;
   int         cyc = 0;

   tcs_conn_mem i_tcs_conn_mem (
      .I_MCLK(clk), .I_RESETN(rst_n), .I_CS_N(cs_n), .I_DS(ds), .I_RW(rw),
      .I_ADDR(addr), .I_DATA(wd), .O_DATA(rdat), .O_DATA_OE(oe), .O_DTA_N(dta_n),
      .I_GLOBAL_OUTPUT_DRIVE_PIN(pin), .I_CTL_DRIVE_OFF(ctl), .I_SLOT_VALID(sv),
      .I_SLOT_LOC(sloc), .O_SLOT_READY(srdy), .O_DM_ADDR(dma), .I_DM_DATA(dmd),
      .O_TX_VALID(txv), .I_TX_READY(txr), .O_TX_LOC(txl), .O_TX_BYTE(txb),
      .O_TX_DRIVE(drv), .O_TX_CONST_DELAY(cd), .O_TX_GAIN_STEP(gs), .O_TX_MUTE(mute),
      .O_TX_CONF(conf), .O_TX_NOISE_SUPPRESSION_LEVEL(ns), .O_TX_INVERT(inv),
      .O_DCH_RX_SRC(dch), .O_ED_A_SRC(eda), .O_ED_B_SRC(edb));
   tcs_dm_model i_tcs_dm_model (.i_addr(dma), .o_data(dmd));

   // ---------------------------------------------
   // Clock, hang guard and shared tasks
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Guard sized well above the 30 accesses of the run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Pins held until the acknowledge edge; read data taken at that edge
   task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #10;
      cs_n = 1'b0;
      ds = 1'b1;
      rw = r;
      addr = a;
      wd = d;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (dta_n === 1'b0) break;
      end
      // Bus enable must follow the direction of the access
      chk(oe, r);
      if (r) chk(rdat, d);
      #10 cs_n = 1'b1;
      ds = 1'b0;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (dta_n === 1'b1) break;
      end
      repeat (3) @(posedge clk);
   endtask

   task automatic put_slot(input logic [6:0] l);
      @(posedge clk) #10;
      sv = 1'b1;
      sloc = l;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (srdy === 1'b1) break;
      end
      #10 sv = 1'b0;
   endtask

   task automatic get_chk(input logic [26:0] e);
      logic [26:0] w;
      w = 27'h0;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (txv === 1'b1 && txr === 1'b1) begin
            w = {txl, txb, drv, cd, gs, mute, conf, ns, inv};
            break;
         end
      end
      chk(w, e);
   endtask

   function automatic logic [26:0] ew(input logic [6:0] l, input logic [7:0] b, input logic dr, c,
                                      input logic [4:0] g, input logic m, cf, input logic [1:0] n, input logic iv);
      return {l, b, dr, c, g, m, cf, n, iv};
   endfunction

   task automatic set_pins(input logic p, input logic c);
      @(posedge clk) #10;
      pin = p;
      ctl = c;
      repeat (5) @(posedge clk);
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_regs;
      acc(1'b1, 8'h85, 8'h00);
      acc(1'b0, 8'h85, 8'h53);
      acc(1'b1, 8'h85, 8'h53);
      acc(1'b0, 8'hF2, 8'h5A);
      acc(1'b1, 8'hF2, 8'h00);
      $display("done regs");
   endtask

   // Every block code except the internal one reads data memory at block and channel
   task automatic t_switch;
      logic [7:0] lo;
      for (int b = 0; b < 8; b++) begin
         if (b == 3) continue;
         lo = {b[2:0], 5'h13};
         acc(1'b0, 8'h05, lo);
         put_slot(7'h05);
         get_chk(ew(7'h05, ~lo, 1'b1, 1'b1, 5'h0A, 1'b0, 1'b0, 2'h0, 1'b0));
      end
      $display("done switch");
   endtask

   task automatic t_msg;
      acc(1'b0, 8'h86, 8'hFC);
      acc(1'b0, 8'h06, 8'h3C);
      put_slot(7'h06);
      get_chk(ew(7'h06, 8'h3C, 1'b0, 1'b0, 5'h1F, 1'b1, 1'b0, 2'h0, 1'b0));
      set_pins(1'b0, 1'b0);
      put_slot(7'h05);
      get_chk(ew(7'h05, 8'h0C, 1'b0, 1'b1, 5'h0A, 1'b0, 1'b0, 2'h0, 1'b0));
      set_pins(1'b1, 1'b1);
      put_slot(7'h06);
      get_chk(ew(7'h06, 8'h3C, 1'b1, 1'b0, 5'h1F, 1'b1, 1'b0, 2'h0, 1'b0));
      set_pins(1'b1, 1'b0);
      $display("done message and drive");
   endtask

   // Internal block: last bridge, unused, transmit buffer, unused top
   task automatic t_blk3;
      logic [7:0] lo [4] = '{8'h6E, 8'h6F, 8'h70, 8'h7F};
      logic [7:0] by [4] = '{8'h91, 8'hFF, 8'h8F, 8'hFF};
      acc(1'b0, 8'h87, 8'h01);
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 8'h07, lo[i]);
         put_slot(7'h07);
         get_chk(ew(7'h07, by[i], 1'b1, 1'b0, 5'h00, 1'b0, 1'b0, 2'h0, 1'b0));
      end
      $display("done internal block");
   endtask

   task automatic t_conf;
      logic [6:0] lc [4] = '{7'h60, 7'h61, 7'h6D, 7'h6E};
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, {1'b1, lc[i]}, 8'h1C | 8'(i));
         acc(1'b0, {1'b0, lc[i]}, 8'h21);
         put_slot(lc[i]);
         get_chk(ew(lc[i], 8'hDE, 1'b0, 1'b0, 5'h03, 1'b0, 1'b1, i[1:0], 1'b1));
      end
      $display("done conference");
   endtask

   task automatic t_route;
      acc(1'b0, 8'h6F, 8'h11);
      acc(1'b0, 8'h70, 8'h22);
      acc(1'b0, 8'h71, 8'h44);
      chk(dch, 8'h11);
      chk(eda, 8'h22);
      chk(edb, 8'h44);
      $display("done routing");
   endtask

   // Reader stalls: two words fill the path, then slot ready must be low
   task automatic t_buf;
      @(posedge clk) #10 txr = 1'b0;
      put_slot(7'h05);
      put_slot(7'h06);
      repeat (3) @(posedge clk);
      chk(srdy, 1'b0);
      @(posedge clk) #10 txr = 1'b1;
      get_chk(ew(7'h05, 8'h0C, 1'b1, 1'b1, 5'h0A, 1'b0, 1'b0, 2'h0, 1'b0));
      get_chk(ew(7'h06, 8'h3C, 1'b0, 1'b0, 5'h1F, 1'b1, 1'b0, 2'h0, 1'b0));
      $display("done buffer");
   endtask

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      cs_n = 1'b1;
      ds = 1'b0;
      rw = 1'b1;
      addr = 8'h00;
      wd = 8'h00;
      pin = 1'b1;
      ctl = 1'b0;
      sv = 1'b0;
      sloc = 7'h00;
      txr = 1'b1;
      repeat (8) @(posedge clk);
      #10 rst_n = 1'b1;
      t_regs();
      t_switch();
      t_msg();
      t_blk3();
      t_conf();
      t_route();
      t_buf();
      give_verdict();
   end
endmodule
